// [rtl/acc_pkg.sv]
// Function
// - separate 2-bit playback and capture law selects
// - playback loopback feeds received word to transmit
// - capture loopback feeds capture samples to playback
// - packed mode forces 8-bit interface word length
// - mu-law inverts all eight code bits
// - A-law inverts even code bits only
// - compressed byte sits in word MSBs
// - mu-law 13-bit, A-law 12-bit magnitude to 8-bit
// - eight segments, finer steps at low amplitude
// - code is sign, 3-bit exponent, 4-bit mantissa
// - piecewise G.711 curves, mu 255, A 87.6
`default_nettype none
package acc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int          ACC_REG_W       = 16;
	localparam int          ACC_ADDR_W      = 7;
	localparam logic [6:0]  ACC_CTRL_ADDR   = 7'h05;
	localparam logic [15:0] ACC_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] ACC_CTRL_MASK   = 16'h007f;  // bits above 6 read as zero

	// compressed law selection, code 01 is reserved
	typedef enum logic [1:0] {
		ACC_LAW_OFF,
		ACC_LAW_RSVD,
		ACC_LAW_MU,
		ACC_LAW_A
	} acc_law_t;

	// control register layout, bit 0 at the right
	typedef struct packed {
		logic [8:0] rsvd;
		logic       playLoop;    // bit 6
		logic       packedByte;  // bit 5
		acc_law_t   playLaw;     // bits 4:3
		acc_law_t   capLaw;      // bits 2:1
		logic       capLoop;     // bit 0
	} acc_ctrl_t;

	// ****************************************
	// data words
	// ****************************************
	localparam int ACC_WORD_W = 16;
	typedef struct packed {
		logic                  valid;
		logic [ACC_WORD_W-1:0] data;
	} acc_word_t;

	localparam logic [7:0] ACC_BYTE_PAD = 8'h00;

	// interface word length codes and their bit counts
	localparam logic [1:0] ACC_WL_16   = 2'h0;
	localparam logic [1:0] ACC_WL_20   = 2'h1;
	localparam logic [1:0] ACC_WL_24   = 2'h2;
	localparam logic [5:0] ACC_BITS_8  = 6'h08;
	localparam logic [5:0] ACC_BITS_16 = 6'h10;
	localparam logic [5:0] ACC_BITS_20 = 6'h14;
	localparam logic [5:0] ACC_BITS_24 = 6'h18;
	localparam logic [5:0] ACC_BITS_32 = 6'h20;

	// ****************************************
	// companding constants
	// ****************************************
	localparam logic [13:0] ACC_MU_CLIP     = 14'h1fdf;
	localparam logic [13:0] ACC_MU_BIAS     = 14'h0021;
	localparam logic [15:0] ACC_MU_EXP_BIAS = 16'h0084;
	localparam logic [7:0]  ACC_MU_INV      = 8'hff;
	localparam logic [7:0]  ACC_A_INV       = 8'h55;
	localparam logic [15:0] ACC_A_SEG0_BIAS = 16'h0008;
	localparam logic [15:0] ACC_A_SEGN_BIAS = 16'h0108;
	localparam int          ACC_SEGMENTS    = 8;
	localparam int          ACC_MU_SEG_LSB  = 5;
	localparam int          ACC_A_SEG_LSB   = 4;

endpackage : acc_pkg
`default_nettype wire

// [rtl/acc_compressor.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_compressor
(
	input  wire logic [1:0]  law,
	input  wire logic [15:0] linear,
	output logic      [7:0]  code
);

	logic [13:0] muMag;
	logic [13:0] muBiased;
	logic [2:0]  muSeg;
	logic [3:0]  muMant;
	logic [11:0] aMag;
	logic [2:0]  aSeg;
	logic [3:0]  aMant;
	logic [7:0]  muCode;
	logic [7:0]  aCode;

	// mu-law: 14-bit signed, clipped, biased, then segment search
	always_comb
	begin
		muMag    = linear[15] ? 14'(~linear[15:2] + 14'h0001) : linear[15:2];
		if (muMag > acc_pkg::ACC_MU_CLIP)
			muMag = acc_pkg::ACC_MU_CLIP;
		muBiased = 14'(muMag + acc_pkg::ACC_MU_BIAS);
		muSeg    = 3'h0;
		for (int i = 1; i < acc_pkg::ACC_SEGMENTS; i++)
			if (muBiased[acc_pkg::ACC_MU_SEG_LSB + i])
				muSeg = 3'(i);
		// widen before the add, or the top segment wraps to a zero shift
		muMant   = 4'(muBiased >> ({1'b0, muSeg} + 4'h1));
		// the top biased value overflows the last segment, so saturate
		if (muBiased[13])
		begin
			muSeg  = 3'h7;
			muMant = 4'hf;
		end
		muCode   = {linear[15], muSeg, muMant} ^ acc_pkg::ACC_MU_INV;
	end

	// A-law: 13-bit signed folded to a 12-bit magnitude
	always_comb
	begin
		aMag  = linear[15] ? ~linear[14:3] : linear[14:3];
		aSeg  = 3'h0;
		for (int i = 1; i < acc_pkg::ACC_SEGMENTS; i++)
			if (aMag[acc_pkg::ACC_A_SEG_LSB + i])
				aSeg = 3'(i);
		aMant = (aSeg < 3'h2) ? aMag[4:1] : 4'(aMag >> aSeg);
		aCode = {~linear[15], aSeg, aMant} ^ acc_pkg::ACC_A_INV;
	end

	assign code = (law == acc_pkg::ACC_LAW_A) ? aCode : muCode;

endmodule // acc_compressor
`default_nettype wire

// [rtl/acc_expander.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_expander
(
	input  wire logic [1:0]  law,
	input  wire logic [7:0]  code,
	output logic      [15:0] linear
);

	logic [7:0]  muRaw;
	logic [15:0] muStep;
	logic [7:0]  aRaw;
	logic [15:0] aStep;

	// mu-law: undo the full inversion, rebuild the biased step
	always_comb
	begin
		muRaw  = code ^ acc_pkg::ACC_MU_INV;
		muStep = 16'({muRaw[3:0], 3'h0}) + acc_pkg::ACC_MU_EXP_BIAS;
		muStep = muStep << muRaw[6:4];
	end

	// A-law: undo the even-bit inversion, segment 0 has no implied one
	always_comb
	begin
		aRaw  = code ^ acc_pkg::ACC_A_INV;
		aStep = 16'({aRaw[3:0], 4'h0});
		if (aRaw[6:4] == 3'h0)
			aStep = aStep + acc_pkg::ACC_A_SEG0_BIAS;
		else
			aStep = 16'((aStep + acc_pkg::ACC_A_SEGN_BIAS) << (aRaw[6:4] - 3'h1));
	end

	assign linear = (law == acc_pkg::ACC_LAW_A)
		? (aRaw[7] ? aStep : 16'(-aStep))
		: (muRaw[7] ? 16'(acc_pkg::ACC_MU_EXP_BIAS - muStep) : 16'(muStep - acc_pkg::ACC_MU_EXP_BIAS));

endmodule // acc_expander
`default_nettype wire

// [rtl/acc_companding_codec.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_companding_codec
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	// register port from the serial control interface
	input  wire logic               regWrEn,
	input  wire logic               regRdEn,
	input  wire logic [6:0]         regAddr,
	input  wire logic [15:0]        regWrData,
	output logic      [15:0]        regRdData,
	// normal word length from the audio interface settings
	input  wire logic [1:0]         interfaceWordLength,
	output logic      [5:0]         effWordLength,
	output logic                    packedByteWordForce,
	// capture samples in, serial words out
	input  wire acc_pkg::acc_word_t captureIn,
	output acc_pkg::acc_word_t      txOut,
	// serial words in, playback samples out
	input  wire acc_pkg::acc_word_t receiveIn,
	output acc_pkg::acc_word_t      playOut
);

	// ****************************************
	// decode helpers
	// ****************************************

	// off and the reserved code both mean no companding
	function automatic logic lawActive(input acc_pkg::acc_law_t law);
		lawActive = (law == acc_pkg::ACC_LAW_MU) || (law == acc_pkg::ACC_LAW_A);
	endfunction

	// length code to a bit count; the top code is the longest word
	function automatic logic [5:0] wordBits(input logic [1:0] wl);
		unique case (wl)
			acc_pkg::ACC_WL_16: wordBits = acc_pkg::ACC_BITS_16;
			acc_pkg::ACC_WL_20: wordBits = acc_pkg::ACC_BITS_20;
			acc_pkg::ACC_WL_24: wordBits = acc_pkg::ACC_BITS_24;
			default:            wordBits = acc_pkg::ACC_BITS_32;
		endcase
	endfunction

	// ****************************************
	// control register
	// ****************************************

	// the raw register and its field view share the same bits
	logic [15:0]        ctrlReg;
	acc_pkg::acc_ctrl_t ctrl;
	wire                ctrlHit   = (regAddr == acc_pkg::ACC_CTRL_ADDR);
	wire                ctrlWrite = regWrEn && ctrlHit;
	wire [15:0]         next_ctrl = regWrData & acc_pkg::ACC_CTRL_MASK;

	assign ctrl = acc_pkg::acc_ctrl_t'(ctrlReg);

	// reserved bits are never stored, so they read back as zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrlReg <= acc_pkg::ACC_CTRL_RESET;
		else if (ctrlWrite)
			ctrlReg <= next_ctrl;
	end

	// readback is registered; an unmapped address answers zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= 16'h0000;
		else if (regRdEn)
			regRdData <= ctrlHit ? ctrlReg : 16'h0000;
	end

	// ****************************************
	// word length
	// ****************************************

	// packed mode wins over the normal length setting
	wire [5:0] next_effWordLength = ctrl.packedByte ? acc_pkg::ACC_BITS_8
		: wordBits(interfaceWordLength);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			effWordLength       <= acc_pkg::ACC_BITS_16;
			packedByteWordForce <= 1'b0;
		end
		else
		begin
			effWordLength       <= next_effWordLength;
			packedByteWordForce <= ctrl.packedByte;
		end
	end

	// ****************************************
	// capture path toward the serial interface
	// ****************************************

	// compressor output, only used when a capture law is selected
	logic [7:0] capCode;

	acc_compressor u_compressor
	(
		.law    (ctrl.capLaw),
		.linear (captureIn.data),
		.code   (capCode)
	);

	// the byte goes in the top eight bits, the rest pads with zero
	wire [15:0] capWord = lawActive(ctrl.capLaw)
		? {capCode, acc_pkg::ACC_BYTE_PAD}
		: captureIn.data;

	// playback loopback replaces capture data with the received word
	wire acc_pkg::acc_word_t next_txOut = ctrl.playLoop ? receiveIn
		: acc_pkg::acc_word_t'{valid: captureIn.valid, data: capWord};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			txOut <= '0;
		else
			txOut <= next_txOut;
	end

	// ****************************************
	// playback path from the serial interface
	// ****************************************

	// expander output, ignored while the playback law is off
	logic [15:0] playLinear;

	// the received byte is taken from the top of the word
	acc_expander u_expander
	(
		.law    (ctrl.playLaw),
		.code   (receiveIn.data[15:8]),
		.linear (playLinear)
	);

	wire [15:0] playWord = lawActive(ctrl.playLaw) ? playLinear : receiveIn.data;

	// capture loopback skips the serial interface and any companding,
	// so the converter sees exactly the linear capture sample
	wire acc_pkg::acc_word_t next_playOut = ctrl.capLoop ? captureIn
		: acc_pkg::acc_word_t'{valid: receiveIn.valid, data: playWord};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			playOut <= '0;
		else
			playOut <= next_playOut;
	end

	// ****************************************
	// checks
	// ****************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire capMu    = (ctrl.capLaw == acc_pkg::ACC_LAW_MU) && !ctrl.playLoop;
	wire capA     = (ctrl.capLaw == acc_pkg::ACC_LAW_A) && !ctrl.playLoop;
	wire capPlain = !lawActive(ctrl.capLaw) && !ctrl.playLoop;
	wire playPlain = !lawActive(ctrl.playLaw) && !ctrl.capLoop;

	sequence s_ctrlWrite;
		ctrlWrite;
	endsequence

	sequence s_ctrlHolds;
		!ctrlWrite [*2];
	endsequence

	sequence s_muFullByte;
		(ctrl.playLaw == acc_pkg::ACC_LAW_MU) && !ctrl.capLoop && receiveIn.valid
			&& (receiveIn.data[15:8] == 8'hff);
	endsequence

	sequence s_aZeroByte;
		(ctrl.playLaw == acc_pkg::ACC_LAW_A) && !ctrl.capLoop && receiveIn.valid
			&& (receiveIn.data[15:8] == 8'hd5);
	endsequence

	a_ctrl_write_holds: assert property (
		s_ctrlWrite ##1 s_ctrlHolds |-> ctrlReg == $past(next_ctrl, 2))
		else $error("control register lost a written value");

	a_play_loop_tx: assert property (
		ctrl.playLoop |=> txOut == $past(receiveIn))
		else $error("playback loopback did not reach transmit");

	a_cap_loop_play: assert property (
		ctrl.capLoop |=> playOut == $past(captureIn))
		else $error("capture loopback did not reach playback");

	a_packed_length: assert property (
		ctrl.packedByte && !ctrlWrite |=> effWordLength == acc_pkg::ACC_BITS_8 && packedByteWordForce)
		else $error("packed mode did not force an 8-bit word");

	a_mu_zero_inverted: assert property (
		capMu && captureIn.valid && captureIn.data == 16'h0000 |=> txOut.data == 16'hff00 && txOut.valid)
		else $error("mu-law zero not sent as all ones");

	a_a_zero_even: assert property (
		capA && captureIn.data == 16'h0000 |=> txOut.data[15:8] == 8'hd5)
		else $error("A-law zero lacks even-bit inversion");

	a_byte_in_msbs: assert property (
		(capMu || capA) |=> txOut.data[7:0] == acc_pkg::ACC_BYTE_PAD)
		else $error("compressed byte not in the upper bits");

	a_mu_segment: assert property (
		capMu && captureIn.data == 16'h0100 |=> txOut.data[15:8] == 8'he7)
		else $error("mu-law segment or mantissa wrong");

	a_a_segment: assert property (
		capA && captureIn.data == 16'h0100 |=> txOut.data[15:8] == 8'hc5)
		else $error("A-law segment or mantissa wrong");

	a_mu_full_scale: assert property (
		capMu && captureIn.data == 16'h7fff |=> txOut.data[15:8] == 8'h80)
		else $error("mu-law full scale code wrong");

	a_mu_expand_zero: assert property (
		s_muFullByte |=> playOut.data == 16'h0000 && playOut.valid)
		else $error("mu-law zero code did not expand to zero");

	a_plain_passthru: assert property (
		capPlain |=> txOut == $past(captureIn))
		else $error("linear capture sample was altered");

	a_play_plain: assert property (
		playPlain |=> playOut == $past(receiveIn))
		else $error("linear playback word was altered");

	// valid must track its own source, or a loopback could drop or invent words
	a_tx_valid_follow: assert property (
		!ctrl.playLoop |=> txOut.valid == $past(captureIn.valid))
		else $error("transmit valid did not follow capture");

	a_play_valid_follow: assert property (
		!ctrl.capLoop |=> playOut.valid == $past(receiveIn.valid))
		else $error("playback valid did not follow receive");

	a_len_normal: assert property (
		!ctrl.packedByte && interfaceWordLength == acc_pkg::ACC_WL_16
			|=> effWordLength == acc_pkg::ACC_BITS_16)
		else $error("normal word length not used");

	a_packed_force_off: assert property (
		!ctrl.packedByte |=> !packedByteWordForce)
		else $error("packed flag raised without packed mode");

	a_mu_neg_full: assert property (
		capMu && captureIn.data == 16'h8000 |=> txOut.data[15:8] == 8'h00)
		else $error("mu-law negative full scale code wrong");

	a_a_neg_full: assert property (
		capA && captureIn.data == 16'h8000 |=> txOut.data[15:8] == 8'h2a)
		else $error("A-law negative full scale code wrong");

	a_a_full_scale: assert property (
		capA && captureIn.data == 16'h7fff |=> txOut.data[15:8] == 8'haa)
		else $error("A-law full scale code wrong");

	// the top unsaturated segment has the widest mantissa shift
	a_mu_top_seg: assert property (
		capMu && captureIn.data == 16'h4000 |=> txOut.data[15:8] == 8'h8f)
		else $error("mu-law top segment code wrong");

	a_a_top_seg: assert property (
		capA && captureIn.data == 16'h4000 |=> txOut.data[15:8] == 8'ha5)
		else $error("A-law top segment code wrong");

	a_a_expand_zero: assert property (
		s_aZeroByte |=> playOut.data == 16'h0008 && playOut.valid)
		else $error("A-law zero code did not expand to the first step");

	a_mu_expand_full: assert property (
		(ctrl.playLaw == acc_pkg::ACC_LAW_MU) && !ctrl.capLoop && receiveIn.data[15:8] == 8'h80
			|=> playOut.data == 16'h7d7c)
		else $error("mu-law full scale code did not expand");

	// ****************************************
	// read port checks
	// ****************************************

	// readback answers one cycle after the strobe and then holds
	a_rd_ctrl_value: assert property (
		regRdEn && ctrlHit |=> regRdData == $past(ctrlReg))
		else $error("control readback wrong");

	a_rd_other_zero: assert property (
		regRdEn && !ctrlHit |=> regRdData == 16'h0000)
		else $error("unmapped read did not answer zero");

	a_rd_data_holds: assert property (
		!regRdEn |=> $stable(regRdData))
		else $error("read data changed without a strobe");

	a_ctrl_rsvd_zero: assert property (
		ctrl.rsvd == 9'h000)
		else $error("reserved control bits were stored");

endmodule // acc_companding_codec
`default_nettype wire

// [bench/acc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_host_model
(
	input  wire logic          clk,
	output acc_pkg::acc_word_t receiveIn
);
	// ****************************************
	// serial host side
	// ****************************************
	logic [15:0] lastData;

	// one word per call, launched just after a rising edge
	task automatic put(input logic [15:0] w);
		@(posedge clk);
		#5;
		receiveIn = {1'b1, w};
		lastData = w;
	endtask

	// a released line shows the inverse, so a stale word never passes for fresh data
	task automatic idle();
		@(posedge clk);
		#5;
		receiveIn = {1'b0, ~lastData};
	endtask

	// quiet line from time zero
	initial
	begin
		lastData = 16'h0000;
		receiveIn = {1'b0, 16'hffff};
	end
endmodule // acc_host_model
`default_nettype wire

// [bench/acc_companding_codec_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module acc_companding_codec_tb;
	// ****************************************
	// stimulus and checking
	// ****************************************
	logic               clk;
	logic               rst_n;
	logic               regWrEn;
	logic               regRdEn;
	logic [6:0]         regAddr;
	logic [15:0]        regWrData;
	logic [15:0]        regRdData;
	logic [1:0]         interfaceWordLength;
	logic [5:0]         effWordLength;
	logic               packedByteWordForce;
	acc_pkg::acc_word_t captureIn;
	acc_pkg::acc_word_t txOut;
	acc_pkg::acc_word_t receiveIn;
	acc_pkg::acc_word_t playOut;
	int                 failures;
	int                 samples_checked;
	int                 seed;
	logic [15:0]        txQ[$];
	logic [15:0]        playQ[$];
	logic [15:0]        r1;
	logic [15:0]        r2;
	logic [15:0]        eTx;
	logic [15:0]        ePlay;
	logic [1:0]         law;
	// linear sample, codes and expanded values worked out by hand from the curves
	logic [15:0] linTab[5] = '{16'h0000, 16'h7fff, 16'h8000, 16'h0100, 16'h4000};
	logic [7:0]  muTab[5]  = '{8'hff, 8'h80, 8'h00, 8'he7, 8'h8f};
	logic [7:0]  aTab[5]   = '{8'hd5, 8'haa, 8'h2a, 8'hc5, 8'ha5};
	logic [15:0] muExp[5]  = '{16'h0000, 16'h7d7c, 16'h8284, 16'h0104, 16'h417c};
	logic [15:0] aExp[5]   = '{16'h0008, 16'h7e00, 16'h8200, 16'h0108, 16'h4200};
	logic [5:0]  wlTab[4]  = '{acc_pkg::ACC_BITS_16, acc_pkg::ACC_BITS_20, acc_pkg::ACC_BITS_24, acc_pkg::ACC_BITS_32};

	acc_companding_codec DUT (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.interfaceWordLength(interfaceWordLength), .effWordLength(effWordLength),
		.packedByteWordForce(packedByteWordForce), .captureIn(captureIn), .txOut(txOut),
		.receiveIn(receiveIn), .playOut(playOut));
	acc_host_model host (.clk(clk), .receiveIn(receiveIn));

	// free-running clock, 50 ns period
	always #25 clk = ~clk;

	task automatic give_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic regWrite(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		#5;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge clk);
		#5;
		regWrEn = 1'b0;
		repeat (2) @(posedge clk);
		#5;
	endtask

	// read data is registered at the strobe edge, so it is settled by the next drive slot
	task automatic regRead(input logic [6:0] a, input logic [15:0] ex);
		@(posedge clk);
		#5;
		regRdEn = 1'b1;
		regAddr = a;
		@(posedge clk);
		#5;
		regRdEn = 1'b0;
		`CHK("regRdData", ex, regRdData)
	endtask

	// one capture sample and one received word in the same cycle
	task automatic xfer(input logic [15:0] c, input logic [15:0] r, input logic [15:0] et, input logic [15:0] ep);
		txQ.push_back(et);
		playQ.push_back(ep);
		fork
			host.put(r);
			begin
				@(posedge clk);
				#5;
				captureIn = {1'b1, c};
			end
		join
		fork
			host.idle();
			begin
				@(posedge clk);
				#5;
				captureIn = {1'b0, ~c};
			end
		join
	endtask

	// outputs are looked at mid-cycle, where they are settled; a word with no note is a mismatch
	always @(negedge clk)
	begin
		if (rst_n && txOut.valid === 1'b1)
		begin
			if (txQ.size() == 0)
			begin
				failures++;
				$display("ERROR txOut expected none seen %h", txOut.data);
			end
			else
			begin
				eTx = txQ.pop_front();
				`CHK("txOut", eTx, txOut.data)
			end
		end
		if (rst_n && playOut.valid === 1'b1)
		begin
			if (playQ.size() == 0)
			begin
				failures++;
				$display("ERROR playOut expected none seen %h", playOut.data);
			end
			else
			begin
				ePlay = playQ.pop_front();
				`CHK("playOut", ePlay, playOut.data)
			end
		end
	end

	// a hang counts as a mismatch and still ends in the verdict
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("ERROR watchdog expected done seen hang");
		give_verdict();
	end

	initial
	begin
		clk = 0;
		rst_n = 0;
		regWrEn = 0;
		regRdEn = 0;
		regAddr = 7'h00;
		regWrData = 16'h0000;
		interfaceWordLength = 2'h0;
		captureIn = 17'h00000;
		failures = 0;
		samples_checked = 0;
		seed = 60;
		repeat (10) @(posedge clk);
		#5;
		rst_n = 1;
		regRead(acc_pkg::ACC_CTRL_ADDR, acc_pkg::ACC_CTRL_RESET);
		`CHK("effWordLength", acc_pkg::ACC_BITS_16, effWordLength)
		`CHK("packedByteWordForce", 1'b0, packedByteWordForce)
		regRead(7'h06, 16'h0000);
		$display("test reset done");
		regWrite(acc_pkg::ACC_CTRL_ADDR, 16'hffff);
		regRead(acc_pkg::ACC_CTRL_ADDR, 16'h007f);
		regWrite(7'h06, 16'h0000);
		regRead(acc_pkg::ACC_CTRL_ADDR, 16'h007f);
		$display("test register done");
		for (int i = 0; i < 8; i++)
		begin
			interfaceWordLength = i[1:0];
			regWrite(acc_pkg::ACC_CTRL_ADDR, {10'h000, i[2], 5'h00});
			`CHK("effWordLength", i[2] ? acc_pkg::ACC_BITS_8 : wlTab[i[1:0]], effWordLength)
			`CHK("packedByteWordForce", i[2], packedByteWordForce)
		end
		interfaceWordLength = 2'h0;
		$display("test word length done");
		for (int l = 0; l < 2; l++)
		begin
			law = l ? acc_pkg::ACC_LAW_A : acc_pkg::ACC_LAW_MU;
			regWrite(acc_pkg::ACC_CTRL_ADDR, {11'h000, law, law, 1'b0});
			for (int k = 0; k < 5; k++)
				xfer(linTab[k], {l ? aTab[k] : muTab[k], 8'h00}, {l ? aTab[k] : muTab[k], 8'h00},
					l ? aExp[k] : muExp[k]);
		end
		$display("test companding done");
		for (int l = 0; l < 2; l++)
		begin
			regWrite(acc_pkg::ACC_CTRL_ADDR, {11'h000, l[1:0], l[1:0], 1'b0});
			repeat (4)
			begin
				r1 = 16'($random(seed));
				r2 = 16'($random(seed));
				xfer(r1, r2, r1, r2);
			end
		end
		$display("test passthrough done");
		regWrite(acc_pkg::ACC_CTRL_ADDR, 16'h0055);
		repeat (4)
		begin
			r1 = 16'($random(seed));
			r2 = 16'($random(seed));
			xfer(r1, r2, r2, r1);
		end
		repeat (4) @(posedge clk);
		`CHK("txQ left", 0, txQ.size())
		`CHK("playQ left", 0, playQ.size())
		$display("test loopback done");
		give_verdict();
	end
endmodule // acc_companding_codec_tb
`default_nettype wire
